//--- design/pcc_params.svh
`ifndef PCC_PARAMS_SVH
`define PCC_PARAMS_SVH

// ****************************************
// clock and character framing
// ****************************************
`define PCC_CLK_MHZ          40
`define PCC_BIT_START        1'b0
`define PCC_BIT_STOP         1'b1
`define PCC_CHAR_LAST        4'h8

// ****************************************
// opcodes
// ****************************************
`define PCC_OP_TRIG_A        8'hB1
`define PCC_OP_TRIG_B        8'h55
`define PCC_OP_TRIG_C        8'hC9
`define PCC_OP_TRIG_D        8'h2D
`define PCC_OP_GLOBAL_RESET  8'hD2
`define PCC_OP_MATRIX_RESET  8'hE4
`define PCC_OP_TEST_PULSE    8'h78
`define PCC_OP_BC_RESET      8'h36
`define PCC_OP_RO_RESET      8'h63
`define PCC_OP_WRITE         8'h9C
`define PCC_OP_READ          8'h4E

// ****************************************
// identifiers, roles, response timing
// ****************************************
`define PCC_MCAST_TAG        4'hF
`define PCC_ROLE_INNER       3'h0
`define PCC_ID_LAST          4'h8
`define PCC_TURN_LAST        4'h4
`define PCC_RESP_COUNT       2'h3
`define PCC_RX_QUIET         4'h1

`endif

//--- design/pcc_pkg.sv
package pcc_pkg;

  // ****************************************
  // carriers
  // ****************************************
  typedef struct packed {
    logic       valid;
    logic [7:0] data;
  } pcc_char_t;

  typedef struct packed {
    logic trigger;
    logic global_reset_cmd;
    logic matrix_reset_cmd;
    logic test_pulse;
    logic bunch_counter_reset_cmd;
    logic readout_reset_cmd;
  } pcc_cmd_t;

  typedef struct packed {
    logic        strobe;
    logic [15:0] addr;
    logic [15:0] data;
  } pcc_wr_t;

  typedef struct packed {
    logic        strobe;
    logic [15:0] addr;
  } pcc_rd_t;

  // ****************************************
  // states
  // ****************************************
  typedef enum logic [3:0] {
    S_OPCODE, S_WR_ID, S_WR_ADDR_LO, S_WR_ADDR_HI, S_WR_DATA_LO, S_WR_DATA_HI,
    S_RD_ID, S_RD_ADDR_LO, S_RD_ADDR_HI, S_RD_WAIT, S_TURN, S_RESP
  } pcc_state_t;

  typedef struct packed {
    logic      sync1;
    logic      sync2;
    logic      busy;
    logic [3:0] cnt;
    logic [7:0] shift;
    pcc_char_t ch;
    logic      frame_err;
  } pcc_rx_st_t;

  typedef struct packed {
    logic       busy;
    logic [3:0] cnt;
    logic [8:0] shift;
    logic       line;
  } pcc_tx_st_t;

  typedef struct packed {
    pcc_state_t  st;
    logic [6:0]  gid1;
    logic [6:0]  gid2;
    logic        role_inner;
    logic        id_in_range;
    logic        local_bus_en;
    logic        sel;
    logic [15:0] addr;
    logic [15:0] data;
    pcc_cmd_t    cmd;
    pcc_wr_t     wr;
    pcc_rd_t     rd;
    logic        drive;
    logic [3:0]  turn;
    logic [1:0]  idx;
    logic        tx_send;
    logic [7:0]  tx_byte;
  } pcc_top_st_t;

endpackage : pcc_pkg

//--- design/pcc_char_rx.sv
`timescale 1ns/1ps
`default_nettype none
`include "pcc_params.svh"

module pcc_char_rx
  import pcc_pkg::*;
(
  input  wire logic      ref_clk,
  input  wire logic      resetn,
  input  wire logic      line_in,
  input  wire logic      rx_enable,
  output var  pcc_char_t rx_char,
  output var  logic      frame_err
);

  pcc_rx_st_t s;
  pcc_rx_st_t next_s;

  // ****************************************
  // character framing
  // ****************************************
  always_comb begin
    next_s           = s;
    next_s.sync1     = line_in;
    next_s.sync2     = s.sync1;
    next_s.ch.valid  = 1'b0;
    next_s.frame_err = 1'b0;
    if (!s.busy) begin
      if (rx_enable && s.sync2 == `PCC_BIT_START) begin
        next_s.busy = 1'b1;
        next_s.cnt  = 4'h0;
      end
    end else if (s.cnt != `PCC_CHAR_LAST) begin
      next_s.shift = {s.sync2, s.shift[7:1]};
      next_s.cnt   = s.cnt + 4'h1;
    end else begin
      next_s.busy = 1'b0;
      if (s.sync2 == `PCC_BIT_STOP) begin
        next_s.ch.valid = 1'b1;
        next_s.ch.data  = s.shift;
      end else begin
        next_s.frame_err = 1'b1;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      s <= '{sync1: 1'b1, sync2: 1'b1, default: '0};
    end else begin
      s <= next_s;
    end
  end

  assign rx_char   = s.ch;
  assign frame_err = s.frame_err;

  // ****************************************
  // checks
  // ****************************************
  property p_rx_stop;
    @(posedge ref_clk) disable iff (!resetn)
    rx_char.valid |-> ($past(s.sync2) == `PCC_BIT_STOP) && ($past(s.cnt) == `PCC_CHAR_LAST);
  endproperty
  a_rx_stop: assert property (p_rx_stop) else $error("char without stop bit");

  property p_rx_length;
    @(posedge ref_clk) disable iff (!resetn)
    (!s.busy && rx_enable && !s.sync2) |=> s.busy ##8 (s.busy && s.cnt == `PCC_CHAR_LAST);
  endproperty
  a_rx_length: assert property (p_rx_length) else $error("char length wrong");

endmodule : pcc_char_rx

`default_nettype wire

//--- design/pcc_char_tx.sv
`timescale 1ns/1ps
`default_nettype none
`include "pcc_params.svh"

module pcc_char_tx
  import pcc_pkg::*;
(
  input  wire logic       ref_clk,
  input  wire logic       resetn,
  input  wire logic       send,
  input  wire logic [7:0] send_byte,
  output var  logic       busy,
  output var  logic       line_out
);

  pcc_tx_st_t s;
  pcc_tx_st_t next_s;

  // ****************************************
  // character serializer
  // ****************************************
  always_comb begin
    next_s      = s;
    next_s.line = `PCC_BIT_STOP;
    if (!s.busy) begin
      if (send) begin
        next_s.line  = `PCC_BIT_START;
        next_s.shift = {`PCC_BIT_STOP, send_byte};
        next_s.cnt   = 4'h0;
        next_s.busy  = 1'b1;
      end
    end else begin
      next_s.line  = s.shift[0];
      next_s.shift = {`PCC_BIT_STOP, s.shift[8:1]};
      next_s.cnt   = s.cnt + 4'h1;
      if (s.cnt == `PCC_CHAR_LAST) begin
        next_s.busy = 1'b0;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      s <= '{line: 1'b1, default: '0};
    end else begin
      s <= next_s;
    end
  end

  assign busy     = s.busy;
  assign line_out = s.line;

  // ****************************************
  // checks
  // ****************************************
  property p_tx_frame;
    @(posedge ref_clk) disable iff (!resetn)
    (send && !s.busy) |=> (!line_out && busy) ##9 line_out;
  endproperty
  a_tx_frame: assert property (p_tx_frame) else $error("tx framing wrong");

endmodule : pcc_char_tx

`default_nettype wire

//--- design/pcc_control_port.sv
// Notes on behaviour
// - characters: start bit 0, eight bits lsb first, stop bit 1
// - accesses carry a 16-bit address and 16-bit data
// - write body: address low, address high, data low, data high
// - opcode 9C starts a write; unicast or multicast identifier follows
// - opcodes B1, 55, C9, 2D are triggers, decoded on a fast path
// - opcode D2 resets the whole chip
// - opcode E4 resets the pixel matrix
// - opcode 78 issues a test pulse to the matrix
// - opcode 36 clears the bunch counter
// - opcode 63 resets the readout units
// - upper three identifier pins choose the role; zero means inner chip
// - lower four identifier pins give stave position; unicast match compares all seven pins
// - inner chips use only the differential port; local bus unused
// - nine chips share one line, each with consecutive identifier
// - identifiers run from first code to last code, one per position
// - port serves register access and trigger/broadcast distribution
// - the line is half duplex; one party drives at a time
// - control logic runs on the 40 MHz main clock
`timescale 1ns/1ps
`default_nettype none
`include "pcc_params.svh"

module pcc_control_port
  import pcc_pkg::*;
(
  input  wire logic        ref_clk,
  input  wire logic        resetn,
  input  wire logic        diff_control_line_in,
  output var  logic        diff_control_line_out,
  output var  logic        diff_control_line_oe,
  input  wire logic [6:0]  geo_id_pins,
  input  wire logic        rd_ack,
  input  wire logic [15:0] rd_data,
  output var  pcc_cmd_t    cmd,
  output var  pcc_wr_t     wr,
  output var  pcc_rd_t     rd_req,
  output var  logic        role_inner,
  output var  logic        id_in_range,
  output var  logic        local_bus_en,
  output var  logic        framing_error
);

  pcc_top_st_t s;
  pcc_top_st_t next_s;
  pcc_char_t   rx_char;
  logic        rx_ferr;
  logic        tx_busy;
  logic        tx_line;

  // ****************************************
  // decode helpers
  // ****************************************
  function automatic logic is_trigger(input logic [7:0] op);
    is_trigger = (op == `PCC_OP_TRIG_A) || (op == `PCC_OP_TRIG_B) ||
                 (op == `PCC_OP_TRIG_C) || (op == `PCC_OP_TRIG_D);
  endfunction : is_trigger

  function automatic logic id_selects(input logic [7:0] id, input logic [6:0] gid,
                                      input logic allow_mcast);
    id_selects = (id[6:0] == gid) || (allow_mcast && id[7:4] == `PCC_MCAST_TAG);
  endfunction : id_selects

  function automatic logic [7:0] resp_byte(input logic [1:0] idx, input logic [6:0] gid,
                                           input logic [15:0] data);
    if (idx == 2'h0) begin
      resp_byte = {1'b0, gid};
    end else if (idx == 2'h1) begin
      resp_byte = data[7:0];
    end else begin
      resp_byte = data[15:8];
    end
  endfunction : resp_byte

  // ****************************************
  // line receiver and transmitter
  // ****************************************
  // receiver off while driving and just after
  pcc_char_rx u_rx (
    .ref_clk   (ref_clk),
    .resetn    (resetn),
    .line_in   (diff_control_line_in),
    .rx_enable (!s.drive && (s.turn == 4'h0)),
    .rx_char   (rx_char),
    .frame_err (rx_ferr)
  );

  pcc_char_tx u_tx (
    .ref_clk   (ref_clk),
    .resetn    (resetn),
    .send      (s.tx_send),
    .send_byte (s.tx_byte),
    .busy      (tx_busy),
    .line_out  (tx_line)
  );

  // ****************************************
  // transaction decoder
  // ****************************************
  always_comb begin
    next_s            = s;
    next_s.gid1       = geo_id_pins;
    next_s.gid2       = s.gid1;
    next_s.role_inner = (s.gid2[6:4] == `PCC_ROLE_INNER);
    next_s.id_in_range = (s.gid2[3:0] <= `PCC_ID_LAST);
    // local bus off for inner chip
    next_s.local_bus_en = (s.gid2[6:4] != `PCC_ROLE_INNER);
    if (!s.drive && s.turn != 4'h0) begin
      next_s.turn = s.turn - 4'h1;
    end
    next_s.cmd        = '0;
    next_s.wr.strobe  = 1'b0;
    next_s.rd.strobe  = 1'b0;
    case (s.st)
      S_OPCODE: begin
        if (rx_char.valid) begin
          if (is_trigger(rx_char.data)) begin
            next_s.cmd.trigger = 1'b1;
          end else if (rx_char.data == `PCC_OP_GLOBAL_RESET) begin
            next_s.cmd.global_reset_cmd = 1'b1;
          end else if (rx_char.data == `PCC_OP_MATRIX_RESET) begin
            next_s.cmd.matrix_reset_cmd = 1'b1;
          end else if (rx_char.data == `PCC_OP_TEST_PULSE) begin
            next_s.cmd.test_pulse = 1'b1;
          end else if (rx_char.data == `PCC_OP_BC_RESET) begin
            next_s.cmd.bunch_counter_reset_cmd = 1'b1;
          end else if (rx_char.data == `PCC_OP_RO_RESET) begin
            next_s.cmd.readout_reset_cmd = 1'b1;
          end else if (rx_char.data == `PCC_OP_WRITE) begin
            next_s.st = S_WR_ID;
          end else if (rx_char.data == `PCC_OP_READ) begin
            next_s.st = S_RD_ID;
          end
        end
      end
      S_WR_ID: begin
        if (rx_char.valid) begin
          next_s.sel = id_selects(rx_char.data, s.gid2, 1'b1);
          next_s.st  = S_WR_ADDR_LO;
        end
      end
      S_WR_ADDR_LO: begin
        if (rx_char.valid) begin
          next_s.addr[7:0] = rx_char.data;
          next_s.st        = S_WR_ADDR_HI;
        end
      end
      S_WR_ADDR_HI: begin
        if (rx_char.valid) begin
          next_s.addr[15:8] = rx_char.data;
          next_s.st         = S_WR_DATA_LO;
        end
      end
      S_WR_DATA_LO: begin
        if (rx_char.valid) begin
          next_s.data[7:0] = rx_char.data;
          next_s.st        = S_WR_DATA_HI;
        end
      end
      S_WR_DATA_HI: begin
        if (rx_char.valid) begin
          next_s.wr.strobe = s.sel;
          next_s.wr.addr   = s.addr;
          next_s.wr.data   = {rx_char.data, s.data[7:0]};
          next_s.st        = S_OPCODE;
        end
      end
      S_RD_ID: begin
        if (rx_char.valid) begin
          next_s.sel = id_selects(rx_char.data, s.gid2, 1'b0);
          next_s.st  = S_RD_ADDR_LO;
        end
      end
      S_RD_ADDR_LO: begin
        if (rx_char.valid) begin
          next_s.addr[7:0] = rx_char.data;
          next_s.st        = S_RD_ADDR_HI;
        end
      end
      S_RD_ADDR_HI: begin
        if (rx_char.valid) begin
          next_s.rd.strobe = s.sel;
          next_s.rd.addr   = {rx_char.data, s.addr[7:0]};
          next_s.st        = s.sel ? S_RD_WAIT : S_OPCODE;
        end
      end
      S_RD_WAIT: begin
        if (rd_ack) begin
          next_s.data  = rd_data;
          next_s.drive = 1'b1;
          next_s.turn  = 4'h0;
          next_s.st    = S_TURN;
        end
      end
      S_TURN: begin
        next_s.turn = s.turn + 4'h1;
        if (s.turn == `PCC_TURN_LAST) begin
          next_s.idx = 2'h0;
          next_s.st  = S_RESP;
        end
      end
      S_RESP: begin
        if (s.tx_send) begin
          next_s.tx_send = 1'b0;
        end else if (!tx_busy) begin
          if (s.idx == `PCC_RESP_COUNT) begin
            next_s.drive = 1'b0;
            next_s.turn  = `PCC_RX_QUIET;
            next_s.st    = S_OPCODE;
          end else begin
            next_s.tx_send = 1'b1;
            next_s.tx_byte = resp_byte(s.idx, s.gid2, s.data);
            next_s.idx     = s.idx + 2'h1;
          end
        end
      end
      default: begin
        next_s.st = S_OPCODE;
      end
    endcase
    if (rx_ferr && !s.drive) begin
      next_s.st = S_OPCODE;
    end
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign cmd                   = s.cmd;
  assign wr                    = s.wr;
  assign rd_req                = s.rd;
  assign role_inner            = s.role_inner;
  assign id_in_range           = s.id_in_range;
  assign local_bus_en          = s.local_bus_en;
  assign diff_control_line_oe  = s.drive;
  assign diff_control_line_out = tx_line;
  assign framing_error         = rx_ferr;

  // ****************************************
  // checks
  // ****************************************
  property p_trigger_fast;
    @(posedge ref_clk) disable iff (!resetn)
    (s.st == S_OPCODE && rx_char.valid && is_trigger(rx_char.data)) |=> cmd.trigger;
  endproperty
  a_trigger_fast: assert property (p_trigger_fast) else $error("trigger missed");

  property p_global_reset;
    @(posedge ref_clk) disable iff (!resetn)
    cmd.global_reset_cmd |-> $past(rx_char.data) == `PCC_OP_GLOBAL_RESET && !cmd.trigger;
  endproperty
  a_global_reset: assert property (p_global_reset) else $error("bad global reset");

  property p_matrix_reset;
    @(posedge ref_clk) disable iff (!resetn)
    (s.st == S_OPCODE && rx_char.valid && rx_char.data == `PCC_OP_MATRIX_RESET)
      |=> cmd.matrix_reset_cmd ##1 !cmd.matrix_reset_cmd;
  endproperty
  a_matrix_reset: assert property (p_matrix_reset) else $error("matrix reset wrong");

  property p_test_pulse;
    @(posedge ref_clk) disable iff (!resetn)
    cmd.test_pulse |-> $past(s.st) == S_OPCODE && $past(rx_char.data) == `PCC_OP_TEST_PULSE;
  endproperty
  a_test_pulse: assert property (p_test_pulse) else $error("bad test pulse");

  property p_bc_reset;
    @(posedge ref_clk) disable iff (!resetn)
    (s.st == S_OPCODE && rx_char.valid && rx_char.data == `PCC_OP_BC_RESET)
      |=> cmd.bunch_counter_reset_cmd;
  endproperty
  a_bc_reset: assert property (p_bc_reset) else $error("bunch counter clear missed");

  property p_ro_reset;
    @(posedge ref_clk) disable iff (!resetn)
    cmd.readout_reset_cmd |-> $past(rx_char.data) == `PCC_OP_RO_RESET;
  endproperty
  a_ro_reset: assert property (p_ro_reset) else $error("bad readout reset");

  property p_write_order;
    @(posedge ref_clk) disable iff (!resetn)
    wr.strobe |-> $past(s.st) == S_WR_DATA_HI && $past(rx_char.data) == wr.data[15:8]
                  && $past(s.sel);
  endproperty
  a_write_order: assert property (p_write_order) else $error("write order wrong");

  property p_read_unicast;
    @(posedge ref_clk) disable iff (!resetn)
    rd_req.strobe |-> $past(s.st) == S_RD_ADDR_HI && $past(s.sel) && s.st == S_RD_WAIT;
  endproperty
  a_read_unicast: assert property (p_read_unicast) else $error("read not selected");

  property p_half_duplex;
    @(posedge ref_clk) disable iff (!resetn)
    diff_control_line_oe |-> !rx_char.valid;
  endproperty
  a_half_duplex: assert property (p_half_duplex) else $error("rx while driving");

  property p_turnaround;
    @(posedge ref_clk) disable iff (!resetn)
    (s.st == S_RD_WAIT && rd_ack) |=> (diff_control_line_oe && diff_control_line_out) [*5];
  endproperty
  a_turnaround: assert property (p_turnaround) else $error("turnaround not idle");

  property p_role_bus;
    @(posedge ref_clk) disable iff (!resetn)
    (s.gid2[6:4] == `PCC_ROLE_INNER) [*2] |=> !local_bus_en;
  endproperty
  a_role_bus: assert property (p_role_bus) else $error("local bus on in inner role");

endmodule : pcc_control_port

`default_nettype wire

//--- verif/pcc_master_model.sv
`timescale 1ns/1ps
`default_nettype none

// ****************************************
// control master model
// ****************************************
module pcc_master_model (
  input  wire logic       ref_clk,
  input  wire logic       resetn,
  input  wire logic       send,
  input  wire logic [7:0] send_byte,
  input  wire logic       bad_stop,
  input  wire logic       release_line,
  input  wire logic       chip_oe,
  output var  logic       busy,
  output var  logic       line_out,
  output var  logic       drive
);
  logic [9:0] sh;
  logic [3:0] cnt;
  logic       seen;

  // start 0, lsb first, stop 1
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      sh   <= 10'h3FF;
      cnt  <= 4'h0;
      seen <= 1'b0;
    end else begin
      seen <= release_line & (seen | chip_oe);
      if (send && cnt == 4'h0) begin
        sh  <= {~bad_stop, send_byte, 1'b0};
        cnt <= 4'hA;
      end else if (cnt != 4'h0) begin
        sh  <= {1'b1, sh[9:1]};
        cnt <= cnt - 4'h1;
      end
    end
  end

  assign busy     = cnt != 4'h0;
  assign line_out = sh[0];
  assign drive    = !release_line | (seen & !chip_oe);
endmodule : pcc_master_model

`default_nettype wire

//--- verif/pixel_chip_control_port_tb_top.sv
`timescale 1ns/1ps
`default_nettype none

module pixel_chip_control_port_tb_top
  import pcc_pkg::*;
;
  typedef struct packed {
    logic [7:0] op;
    logic [5:0] exp;
  } pcc_row_t;

  localparam pcc_row_t rows [0:9] = '{'{8'hB1, 6'h20}, '{8'h55, 6'h20}, '{8'hC9, 6'h20},
    '{8'h2D, 6'h20}, '{8'hD2, 6'h10}, '{8'hE4, 6'h08}, '{8'h78, 6'h04}, '{8'h36, 6'h02},
    '{8'h63, 6'h01}, '{8'h00, 6'h00}};

  logic        ref_clk, resetn, rd_ack, send, bad_stop, release_line, last;
  logic [6:0]  geo;
  logic [15:0] rd_data;
  logic [7:0]  send_byte, rsh;
  logic        line, line_out, line_oe, m_line, m_drive, m_busy;
  logic        role_inner, id_in_range, local_bus_en, framing_error;
  pcc_cmd_t    cmd, acc;
  pcc_wr_t     wr, wr_v;
  pcc_rd_t     rd_req, rd_v;
  logic [7:0]  rq [$];
  int          n_fail, n_checks, n_cmd, n_wr, n_rd, n_fe, bitn, ones, cyc;

  assign line = line_oe ? line_out : (m_drive ? m_line : ~last);

  pcc_control_port i_dut (
    .ref_clk(ref_clk), .resetn(resetn), .diff_control_line_in(line),
    .diff_control_line_out(line_out), .diff_control_line_oe(line_oe),
    .geo_id_pins(geo), .rd_ack(rd_ack), .rd_data(rd_data), .cmd(cmd), .wr(wr),
    .rd_req(rd_req), .role_inner(role_inner), .id_in_range(id_in_range),
    .local_bus_en(local_bus_en), .framing_error(framing_error));

  pcc_master_model i_master (
    .ref_clk(ref_clk), .resetn(resetn), .send(send), .send_byte(send_byte),
    .bad_stop(bad_stop), .release_line(release_line), .chip_oe(line_oe),
    .busy(m_busy), .line_out(m_line), .drive(m_drive));

  // ****************************************
  // clock, timeout, answer decoder
  // ****************************************
  initial begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end

  always @(posedge ref_clk) begin
    last <= line;
    cyc++;
    if (cyc == 5000) begin
      n_fail++;
      stop_test();
    end
    if (line_oe === 1'b1) begin
      if (bitn == 0) begin
        if (line_out === 1'b0) bitn = 1;
        else if (rq.size() == 0) ones++;
      end else if (bitn < 9) begin
        rsh[bitn-1] = line_out;
        bitn++;
      end else begin
        rq.push_back(rsh);
        bitn = 0;
      end
    end
  end

  // ****************************************
  // tasks
  // ****************************************
  task check(input string name, input logic [39:0] seen, input logic [39:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("BAD %s exp %h seen %h", name, exp, seen);
    end
  endtask : check

  task stop_test;
    $display("checks %0d fails %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : stop_test

  task send_ch(input logic [7:0] b, input logic bs);
    @(posedge ref_clk);
    while (m_busy) @(posedge ref_clk);
    send      <= 1'b1;
    send_byte <= b;
    bad_stop  <= bs;
    @(posedge ref_clk);
    send      <= 1'b0;
  endtask : send_ch

  task watch(input int n);
    acc   = '0;
    n_cmd = 0;
    n_wr  = 0;
    n_rd  = 0;
    n_fe  = 0;
    repeat (n) begin
      @(posedge ref_clk);
      acc = acc | cmd;
      if (cmd !== '0) n_cmd++;
      if (wr.strobe === 1'b1) begin
        n_wr++;
        wr_v = wr;
      end
      if (rd_req.strobe === 1'b1) begin
        n_rd++;
        rd_v = rd_req;
      end
      if (framing_error === 1'b1) n_fe++;
    end
  endtask : watch

  task wr_tx(input logic [7:0] id, input logic [15:0] a, input logic [15:0] d);
    send_ch(8'h9C, 1'b0);
    send_ch(id, 1'b0);
    send_ch(a[7:0], 1'b0);
    send_ch(a[15:8], 1'b0);
    send_ch(d[7:0], 1'b0);
    send_ch(d[15:8], 1'b0);
    watch(20);
  endtask : wr_tx

  task rd_tx(input logic [7:0] id, input logic [15:0] a);
    send_ch(8'h4E, 1'b0);
    send_ch(id, 1'b0);
    send_ch(a[7:0], 1'b0);
    send_ch(a[15:8], 1'b0);
    watch(20);
  endtask : rd_tx

  task pins(input logic [6:0] g);
    geo <= g;
    repeat (6) @(posedge ref_clk);
  endtask : pins

  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    {resetn, rd_ack, rd_data, send, send_byte, bad_stop, release_line} = '0;
    geo = 7'h03;
    repeat (2) @(posedge ref_clk);
    check("rst", {line_oe, line_out, role_inner, local_bus_en, cmd}, 10'h100);
    resetn <= 1'b1;
    repeat (6) @(posedge ref_clk);
    check("role", {role_inner, id_in_range, local_bus_en}, 3'b110);
    for (int i = 0; i < 10; i++) begin
      send_ch(rows[i].op, 1'b0);
      watch(20);
      check("cmd", acc, rows[i].exp);
      check("pulses", n_cmd, rows[i].exp != 6'h00);
    end
    wr_tx(8'h03, 16'h1234, 16'hABCD);
    check("wr_n", n_wr, 1);
    check("wr_val", {wr_v.addr, wr_v.data}, 32'h1234ABCD);
    wr_tx(8'hF5, 16'h00FF, 16'h8001);
    check("mc_val", {n_wr[0], wr_v.addr, wr_v.data}, 33'h1_00FF_8001);
    wr_tx(8'h05, 16'h0101, 16'h0202);
    check("other_wr", n_wr, 0);
    rd_tx(8'h03, 16'h00C5);
    check("rd_req", {n_rd[0], rd_v.addr}, 17'h1_00C5);
    rd_ack  <= 1'b1;
    rd_data <= 16'h5AA5;
    @(posedge ref_clk);
    rd_ack  <= 1'b0;
    for (int k = 0; k < 20 && line_oe !== 1'b1; k++) @(posedge ref_clk);
    release_line <= 1'b1;
    for (int k = 0; k < 200 && line_oe !== 1'b0; k++) @(posedge ref_clk);
    release_line <= 1'b0;
    check("resp", {rq[0], rq[1], rq[2]}, 24'h03A55A);
    check("turn", ones >= 5, 1'b1);
    rd_tx(8'hF3, 16'h0010);
    check("mc_rd", n_rd, 0);
    send_ch(8'h00, 1'b1);
    watch(20);
    check("frame", {n_fe[0], acc}, 7'h40);
    send_ch(8'hB1, 1'b0);
    watch(20);
    check("after_err", acc, 6'h20);
    pins(7'h08);
    check("id_last", id_in_range, 1'b1);
    pins(7'h09);
    check("id_over", id_in_range, 1'b0);
    pins(7'h13);
    check("role_other", {role_inner, local_bus_en}, 2'b01);
    resetn <= 1'b0;
    @(posedge ref_clk);
    check("rst2", {line_oe, line_out, wr.strobe}, 3'b010);
    stop_test();
  end
endmodule : pixel_chip_control_port_tb_top

`default_nettype wire
